//--- core/ivp_params.svh
// Constants for the interrupt vector and priority logic.
// Assumes inclusion by bare name from core design files.
`ifndef IVP_PARAMS_SVH
`define IVP_PARAMS_SVH

// ----------------------------------------------------------------
// Edge selection codes for pin inputs
// ----------------------------------------------------------------
`define IVP_EDGE_NONE 2'h0
`define IVP_EDGE_RISE 2'h1
`define IVP_EDGE_FALL 2'h2
`define IVP_EDGE_BOTH 2'h3

// ----------------------------------------------------------------
// Exception codes and handler addresses
// ----------------------------------------------------------------
`define IVP_RESET_CODE 16'h0000
`define IVP_RESET_ADDR 32'h0000_0000
`define IVP_NMI_PIN_CODE 16'h0010
`define IVP_NMI_PIN_ADDR 32'h0000_0010
`define IVP_NMI_WDA_CODE 16'h0020
`define IVP_NMI_WDA_ADDR 32'h0000_0020
`define IVP_NMI_WDB_CODE 16'h0030
`define IVP_NMI_WDB_ADDR 32'h0000_0030
`define IVP_TRAP_LOW_CODE 16'h0040
`define IVP_TRAP_LOW_ADDR 32'h0000_0040
`define IVP_TRAP_HIGH_CODE 16'h0050
`define IVP_TRAP_HIGH_ADDR 32'h0000_0050
`define IVP_ILLEGAL_CODE 16'h0060
`define IVP_ILLEGAL_ADDR 32'h0000_0060
`define IVP_MASK_BASE_CODE 16'h0080

// ----------------------------------------------------------------
// Maskable slot layout (slot index equals default priority)
// ----------------------------------------------------------------
`define IVP_MASK_SLOTS 22
`define IVP_SLOT_WDA_INTERVAL 0
`define IVP_SLOT_PIN_FIRST 1
`define IVP_PIN_COUNT 7
`define IVP_SLOT_PERIPH_FIRST 8
`define IVP_TRAP_HIGH_BIT 4

`endif

//--- core/ivp_pkg.sv
// Types shared by the interrupt vector and priority logic.
// Assumes no other package.
package ivp_pkg;

  // Class of the source currently presented to the core
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_RESET = 3'b001,
    SRC_EXCEPT = 3'b010,
    SRC_NMI = 3'b011,
    SRC_MASK = 3'b100
  } src_kind_t;

endpackage

//--- core/pin_edge_detect.sv
// Pin synchroniser and selectable valid-edge detector.
// Assumes an asynchronous pin and the single system clock.
`timescale 1ns/10ps
`include "ivp_params.svh"

module pin_edge_detect
  import ivp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_pin,
  input wire logic [1:0] i_edge_sel,
  output logic o_edge
);

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic level_r;
  logic level_nxt;
  logic rise;
  logic fall;

  // Three-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      sync1_r <= i_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= level_nxt;
    end
  end

  // Level only moves once two late stages agree, filtering one-cycle glitches
  assign level_nxt = (sync2_r == sync3_r) ? sync3_r : level_r;
  assign rise = level_nxt & ~level_r;
  assign fall = ~level_nxt & level_r;

  // Valid edge per selection; none disables detection
  assign o_edge = ((i_edge_sel == `IVP_EDGE_RISE) & rise) |
                  ((i_edge_sel == `IVP_EDGE_FALL) & fall) |
                  ((i_edge_sel == `IVP_EDGE_BOTH) & (rise | fall));

endmodule // pin_edge_detect

//--- core/interrupt_vector_priority.sv
// Interrupt and exception source logic: latches requests and presents
// one vector (exception code and handler address) to the CPU core.
// Assumes the core pulses i_ack for one cycle to take the presented vector.
//
// Overview of operation
// - Pin or watchdog reset: code 0000H, address 0
// - Pin edge gives non-maskable request, code 0010H
// - Watchdog A non-maskable overflow gives code 0020H
// - Watchdog B non-maskable overflow gives code 0030H
// - Trap vectors 00H-0FH: code 004nH, address 40H
// - Trap vectors 10H-1FH: code 005nH, address 50H
// - Illegal opcode or debug trap: code 0060H
// - Watchdog A interval overflow: priority 0, 0080H
// - Seven pins: priorities 1-7, codes 0090H-00F0H
// - Timer 01 matches: priorities 10, 11
// - Three non-maskable sources: pin, two watchdogs
// - Twenty-five interrupt sources in total
// - Same-level maskables: lowest default number first
// - Non-maskables: watchdog B, watchdog A, pin
// - Non-maskables ignore disable, beat all maskables
`timescale 1ns/10ps
`include "ivp_params.svh"

module interrupt_vector_priority
  import ivp_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_watchdog_a_reset,
  input wire logic i_watchdog_b_reset,
  input wire logic i_nmi_pin,
  input wire logic [1:0] i_nmi_edge_sel,
  input wire logic i_watchdog_a_overflow,
  input wire logic i_watchdog_a_nmi_mode,
  input wire logic i_watchdog_b_overflow,
  input wire logic i_watchdog_b_nmi_mode,
  input wire logic [6:0] i_ext_pin,
  input wire logic [13:0] i_ext_edge_sel,
  input wire logic [21:8] i_periph_req,
  input wire logic [21:0] i_mask,
  input wire logic i_int_disable,
  input wire logic i_trap_valid,
  input wire logic [4:0] i_trap_vector,
  input wire logic i_illegal_opcode,
  input wire logic i_debug_trap,
  input wire logic i_ack,
  output logic o_req_valid,
  output logic o_req_nonmaskable,
  output logic [15:0] o_exc_code,
  output logic [31:0] o_handler_addr
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic reset_pend_r;
  logic reset_pend_nxt;
  logic except_pend_r;
  logic except_pend_nxt;
  logic [15:0] except_code_r;
  logic [15:0] except_code_nxt;
  logic [31:0] except_addr_r;
  logic [31:0] except_addr_nxt;
  logic [2:0] nmi_pend_r;
  logic [2:0] nmi_pend_nxt;
  logic [21:0] mask_pend_r;
  logic [21:0] mask_pend_nxt;
  logic [21:0] mask_set;
  logic [21:0] mask_clr;
  logic [21:0] mask_eligible;
  logic [6:0] pin_edge;
  logic nmi_pin_edge;
  logic [2:0] nmi_set;
  logic take;
  logic except_new;
  logic [15:0] trap_code;
  logic [31:0] trap_addr;
  src_kind_t kind_r;
  src_kind_t kind_nxt;
  logic [4:0] mask_idx;
  logic mask_any;
  logic [4:0] slot_r;
  logic [4:0] slot_nxt;
  logic [15:0] mask_code;
  logic [15:0] code_nxt;
  logic [31:0] addr_nxt;
  logic nonmask_nxt;

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  // Non-maskable pin with its own edge choice
  pin_edge_detect u_nmi_edge (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_pin(i_nmi_pin),
    .i_edge_sel(i_nmi_edge_sel),
    .o_edge(nmi_pin_edge)
  );

  // One detector per external maskable pin
  genvar gi;
  generate
    for (gi = 0; gi < `IVP_PIN_COUNT; gi = gi + 1) begin : g_pin
      pin_edge_detect u_edge (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_pin(i_ext_pin[gi]),
        .i_edge_sel(i_ext_edge_sel[2*gi+1:2*gi]),
        .o_edge(pin_edge[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Request latching; a new request wins over the clear of its flag
  // ----------------------------------------------------------------
  assign take = i_ack & o_req_valid;

  // Reset pending comes up set; watchdog internal resets set it again
  assign reset_pend_nxt = (i_watchdog_a_reset | i_watchdog_b_reset) |
                          (reset_pend_r & ~(take & (kind_r == SRC_RESET)));

  // Non-maskable sources: bit 0 pin, bit 1 watchdog A, bit 2 watchdog B
  assign nmi_set = {i_watchdog_b_overflow & i_watchdog_b_nmi_mode,
                    i_watchdog_a_overflow & i_watchdog_a_nmi_mode,
                    nmi_pin_edge};
  // Taking the winner discards lower-ranked simultaneous requests
  assign nmi_pend_nxt = nmi_set |
                        (nmi_pend_r & {3{~(take & (kind_r == SRC_NMI))}});

  // Maskable slots: index is default priority (25 sources with the above)
  assign mask_set[`IVP_SLOT_WDA_INTERVAL] =
    i_watchdog_a_overflow & ~i_watchdog_a_nmi_mode;
  assign mask_set[`IVP_SLOT_PERIPH_FIRST-1:`IVP_SLOT_PIN_FIRST] = pin_edge;
  assign mask_set[`IVP_MASK_SLOTS-1:`IVP_SLOT_PERIPH_FIRST] = i_periph_req;
  assign mask_clr = (take && (kind_r == SRC_MASK)) ? (22'h1 << slot_r) : 22'h0;
  assign mask_pend_nxt = mask_set | (mask_pend_r & ~mask_clr);

  // Synchronous exceptions; trap vector upper bit picks the group
  assign trap_code = (i_trap_vector[`IVP_TRAP_HIGH_BIT] ? `IVP_TRAP_HIGH_CODE :
                      `IVP_TRAP_LOW_CODE) | {12'h000, i_trap_vector[3:0]};
  assign trap_addr = i_trap_vector[`IVP_TRAP_HIGH_BIT] ? `IVP_TRAP_HIGH_ADDR :
                     `IVP_TRAP_LOW_ADDR;
  assign except_new = i_trap_valid | i_illegal_opcode | i_debug_trap;
  // Illegal opcode and debug trap outrank a trap in the same cycle
  assign except_code_nxt = (i_illegal_opcode | i_debug_trap) ? `IVP_ILLEGAL_CODE :
                           i_trap_valid ? trap_code : except_code_r;
  assign except_addr_nxt = (i_illegal_opcode | i_debug_trap) ? `IVP_ILLEGAL_ADDR :
                           i_trap_valid ? trap_addr : except_addr_r;
  assign except_pend_nxt = except_new |
                           (except_pend_r & ~(take & (kind_r == SRC_EXCEPT)));

  // ----------------------------------------------------------------
  // Selection from next-state flags so a taken vector never lingers
  // ----------------------------------------------------------------
  // Global disable gates maskables only
  assign mask_eligible = mask_pend_nxt & ~i_mask & {22{~i_int_disable}};

  // Lowest slot number wins among eligible maskables
  always_comb begin
    mask_idx = 5'h00;
    mask_any = 1'b0;
    for (int k = `IVP_MASK_SLOTS - 1; k >= 0; k--) begin
      if (mask_eligible[k]) begin
        mask_idx = k[4:0];
        mask_any = 1'b1;
      end
    end
  end

  // Code steps by 10H per slot; address is the code zero-extended
  assign mask_code = `IVP_MASK_BASE_CODE + {7'h00, mask_idx, 4'h0};

  // Reset, then exceptions, then non-maskables, then maskables
  always_comb begin
    kind_nxt = SRC_NONE;
    slot_nxt = slot_r;
    code_nxt = o_exc_code;
    addr_nxt = o_handler_addr;
    nonmask_nxt = 1'b0;
    if (reset_pend_nxt) begin
      kind_nxt = SRC_RESET;
      code_nxt = `IVP_RESET_CODE;
      addr_nxt = `IVP_RESET_ADDR;
      nonmask_nxt = 1'b1;
    end else if (except_pend_nxt) begin
      kind_nxt = SRC_EXCEPT;
      code_nxt = except_code_nxt;
      addr_nxt = except_addr_nxt;
      nonmask_nxt = 1'b1;
    end else if (nmi_pend_nxt[2]) begin
      kind_nxt = SRC_NMI;
      code_nxt = `IVP_NMI_WDB_CODE;
      addr_nxt = `IVP_NMI_WDB_ADDR;
      nonmask_nxt = 1'b1;
    end else if (nmi_pend_nxt[1]) begin
      kind_nxt = SRC_NMI;
      code_nxt = `IVP_NMI_WDA_CODE;
      addr_nxt = `IVP_NMI_WDA_ADDR;
      nonmask_nxt = 1'b1;
    end else if (nmi_pend_nxt[0]) begin
      kind_nxt = SRC_NMI;
      code_nxt = `IVP_NMI_PIN_CODE;
      addr_nxt = `IVP_NMI_PIN_ADDR;
      nonmask_nxt = 1'b1;
    end else if (mask_any) begin
      kind_nxt = SRC_MASK;
      slot_nxt = mask_idx;
      code_nxt = mask_code;
      addr_nxt = {16'h0000, mask_code};
    end
  end

  // ----------------------------------------------------------------
  // State and output registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      reset_pend_r <= 1'b1;
      except_pend_r <= 1'b0;
      except_code_r <= `IVP_RESET_CODE;
      except_addr_r <= `IVP_RESET_ADDR;
      nmi_pend_r <= 3'h0;
      mask_pend_r <= 22'h0;
      kind_r <= SRC_NONE;
      slot_r <= 5'h00;
    end else begin
      reset_pend_r <= reset_pend_nxt;
      except_pend_r <= except_pend_nxt;
      except_code_r <= except_code_nxt;
      except_addr_r <= except_addr_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      mask_pend_r <= mask_pend_nxt;
      kind_r <= kind_nxt;
      slot_r <= slot_nxt;
    end
  end

  // Presented vector is registered so the core sees stable data
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_req_nonmaskable <= 1'b0;
      o_exc_code <= `IVP_RESET_CODE;
      o_handler_addr <= `IVP_RESET_ADDR;
    end else begin
      o_req_nonmaskable <= nonmask_nxt;
      o_exc_code <= code_nxt;
      o_handler_addr <= addr_nxt;
    end
  end

  assign o_req_valid = (kind_r != SRC_NONE);

endmodule // interrupt_vector_priority

//--- testbench/interrupt_vector_priority_properties.sv
// Checker for the vector presented at the block's core-side ports.
// Assumes one clock and a bind onto every instance of the block.
`timescale 1ns/10ps

module interrupt_vector_priority_chk (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_watchdog_a_reset,
  input wire logic i_watchdog_b_reset,
  input wire logic i_watchdog_a_overflow,
  input wire logic i_watchdog_a_nmi_mode,
  input wire logic i_watchdog_b_overflow,
  input wire logic i_watchdog_b_nmi_mode,
  input wire logic [21:0] i_mask,
  input wire logic i_int_disable,
  input wire logic i_trap_valid,
  input wire logic [4:0] i_trap_vector,
  input wire logic i_illegal_opcode,
  input wire logic i_debug_trap,
  input wire logic i_ack,
  input wire logic o_req_valid,
  input wire logic o_req_nonmaskable,
  input wire logic [15:0] o_exc_code,
  input wire logic [31:0] o_handler_addr
);
  // --------
  // Helpers
  // --------
  // Reset or exception shown or arriving hides every lower source
  wire rst_in = i_watchdog_a_reset | i_watchdog_b_reset;
  wire exc_in = i_trap_valid | i_illegal_opcode | i_debug_trap;
  wire rst_shown = o_req_valid && o_req_nonmaskable && o_exc_code == 16'h0000;
  wire hi_shown = o_req_valid && o_req_nonmaskable &&
    !(o_exc_code inside {16'h0010, 16'h0020, 16'h0030});
  wire wdb_nmi = i_watchdog_b_overflow && i_watchdog_b_nmi_mode;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  // --------
  // Properties
  // --------
  a_reset_vector_first: assert property (
    $rose(i_resetn) |=> o_req_valid && o_req_nonmaskable && o_exc_code == 16'h0000 &&
    o_handler_addr == 32'h0000_0000) else $error("reset vector missing");
  a_wdb_nmi_vector: assert property (
    wdb_nmi && !rst_in && !exc_in && !hi_shown |=> o_req_valid && o_req_nonmaskable &&
    o_exc_code == 16'h0030 && o_handler_addr == 32'h0000_0030) else $error("wdog b nmi");
  a_wda_nmi_vector: assert property (
    i_watchdog_a_overflow && i_watchdog_a_nmi_mode && !wdb_nmi && !rst_in && !exc_in &&
    !hi_shown && !(o_req_valid && o_exc_code == 16'h0030) |=> o_req_valid &&
    o_exc_code == 16'h0020 && o_handler_addr == 32'h0000_0020) else $error("wdog a nmi");
  a_exc_trap_vector: assert property (
    (i_illegal_opcode || i_debug_trap) && !rst_in && !rst_shown |=> o_req_valid &&
    o_exc_code == 16'h0060 && o_handler_addr == 32'h0000_0060) else $error("exception trap");
  a_soft_trap_code: assert property (
    i_trap_valid && !i_illegal_opcode && !i_debug_trap && !rst_in && !rst_shown |=>
    o_exc_code == {11'h002, $past(i_trap_vector)} &&
    o_handler_addr == {16'h0000, o_exc_code & 16'hfff0}) else $error("soft trap vector");
  a_mask_addr_form: assert property (
    o_req_valid && !o_req_nonmaskable |-> o_handler_addr == {16'h0000, o_exc_code} &&
    o_exc_code[3:0] == 4'h0 && o_exc_code inside {[16'h0080:16'h01d0]})
    else $error("maskable vector form");
  a_disable_holds: assert property (
    i_int_disable && $past(i_int_disable) |-> !o_req_valid || o_req_nonmaskable)
    else $error("maskable shown while disabled");
  a_interval_vector: assert property (
    i_watchdog_a_overflow && !i_watchdog_a_nmi_mode && !i_mask[0] && !i_int_disable &&
    !o_req_valid && !rst_in && !exc_in && !wdb_nmi |=> o_req_valid && !o_req_nonmaskable &&
    o_exc_code == 16'h0080) else $error("interval vector");
  a_nmi_flush: assert property (
    i_ack && o_req_valid && o_exc_code == 16'h0030 && !i_watchdog_a_overflow |=>
    !(o_req_valid && o_exc_code inside {16'h0010, 16'h0020})) else $error("nmi not dropped");
endmodule // interrupt_vector_priority_chk

bind interrupt_vector_priority interrupt_vector_priority_chk i_chk (.i_sys_clk, .i_resetn,
  .i_watchdog_a_reset, .i_watchdog_b_reset, .i_watchdog_a_overflow, .i_watchdog_a_nmi_mode,
  .i_watchdog_b_overflow, .i_watchdog_b_nmi_mode, .i_mask, .i_int_disable, .i_trap_valid,
  .i_trap_vector, .i_illegal_opcode, .i_debug_trap, .i_ack, .o_req_valid, .o_req_nonmaskable,
  .o_exc_code, .o_handler_addr);

//--- testbench/cpu_core_model.sv
// Core model that takes presented vectors with a one-cycle acknowledge.
// Assumes a vector stands until acknowledged; acts off the falling edge.
`timescale 1ns/10ps

module cpu_core_model (
  input wire logic i_sys_clk,
  input wire logic i_valid,
  input wire logic i_nm,
  input wire logic [15:0] i_code,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output int o_cnt,
  output logic [15:0] o_code,
  output logic [31:0] o_addr,
  output logic o_nm
);
  int wait_r;
  initial begin
    o_ack = 1'b0;
    o_cnt = 0;
    wait_r = 0;
  end
  // Wait i_delay cycles of a standing vector; never ack two cycles running
  always @(negedge i_sys_clk) begin
    o_ack <= i_valid && !o_ack && wait_r >= i_delay;
    wait_r <= (i_valid && !o_ack) ? wait_r + 1 : 0;
  end
  // Record what the core took, at the edge where ack is sampled
  always @(posedge i_sys_clk) begin
    if (o_ack && i_valid) begin
      o_cnt <= o_cnt + 1;
      o_code <= i_code;
      o_addr <= i_addr;
      o_nm <= i_nm;
    end
  end
endmodule // cpu_core_model

//--- testbench/tb.sv
// Self-checking bench for the interrupt vector and priority block.
// Assumes the core model and the bound checker are compiled before it.
`timescale 1ns/10ps

module tb;
  import ivp_pkg::*;
  // --------
  // Signals
  // --------
  logic i_sys_clk = 1'b0, i_resetn = 1'b0, i_nmi_pin = 1'b0, i_int_disable = 1'b0;
  logic i_watchdog_a_reset = 1'b0, i_watchdog_b_reset = 1'b0, i_trap_valid = 1'b0;
  logic i_watchdog_a_overflow = 1'b0, i_watchdog_b_overflow = 1'b0, i_debug_trap = 1'b0;
  logic i_watchdog_a_nmi_mode = 1'b1, i_watchdog_b_nmi_mode = 1'b1, i_illegal_opcode = 1'b0;
  logic [1:0] i_nmi_edge_sel = 2'h1;
  logic [6:0] i_ext_pin = 7'h00;
  logic [13:0] i_ext_edge_sel = 14'h1555;
  logic [21:8] i_periph_req = 14'h0000;
  logic [21:0] i_mask = 22'h000000;
  logic [4:0] i_trap_vector = 5'h00;
  logic [3:0] delay = 4'h0;
  logic i_ack, o_req_valid, o_req_nonmaskable, tn;
  logic [15:0] o_exc_code, tc;
  logic [31:0] o_handler_addr, ta;
  int cnt, n_errors = 0, num_checks = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  interrupt_vector_priority i_dut (.i_sys_clk, .i_resetn, .i_watchdog_a_reset,
    .i_watchdog_b_reset, .i_nmi_pin, .i_nmi_edge_sel, .i_watchdog_a_overflow,
    .i_watchdog_a_nmi_mode, .i_watchdog_b_overflow, .i_watchdog_b_nmi_mode, .i_ext_pin,
    .i_ext_edge_sel, .i_periph_req, .i_mask, .i_int_disable, .i_trap_valid, .i_trap_vector,
    .i_illegal_opcode, .i_debug_trap, .i_ack, .o_req_valid, .o_req_nonmaskable, .o_exc_code,
    .o_handler_addr);
  cpu_core_model i_core (.i_sys_clk, .i_valid(o_req_valid), .i_nm(o_req_nonmaskable),
    .i_code(o_exc_code), .i_addr(o_handler_addr), .i_delay(delay), .o_ack(i_ack),
    .o_cnt(cnt), .o_code(tc), .o_addr(ta), .o_nm(tn));

  // --------
  // Shared tasks
  // --------
  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic pulse(ref logic s);
    step(1);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  // Bounded wait for exactly one vector to be taken, then compare it
  task automatic take(input logic [15:0] c, input logic [31:0] a, input logic nm);
    int n0;
    n0 = cnt;
    for (int i = 0; i < 40 && cnt == n0; i++) step(1);
    chk("vector taken", {cnt == n0 + 1, tc, ta, tn}, {1'b1, c, a, nm});
  endtask
  task automatic idle();
    step(8);
    chk("no request", o_req_valid, 1'b0);
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reset();
    take(16'h0000, 32'h0, 1'b1);
    pulse(i_watchdog_a_reset);
    take(16'h0000, 32'h0, 1'b1);
    pulse(i_watchdog_b_reset);
    take(16'h0000, 32'h0, 1'b1);
    // Pin reset mid-run must drop a pending trap and bring the reset vector back
    step(1);
    i_trap_valid = 1'b1;
    step(1);
    i_trap_valid = 1'b0;
    i_resetn = 1'b0;
    step(2);
    chk("in reset", {o_req_valid, o_req_nonmaskable, o_exc_code, o_handler_addr}, '0);
    i_resetn = 1'b1;
    take(16'h0000, 32'h0, 1'b1);
    idle();
    $display("test reset done");
  endtask
  task automatic t_exc();
    for (int v = 0; v < 32; v++) begin
      step(1);
      i_trap_valid = 1'b1;
      i_trap_vector = v[4:0];
      step(1);
      i_trap_valid = 1'b0;
      take(16'h0040 + 16'(v), v[4] ? 32'h50 : 32'h40, 1'b1);
    end
    pulse(i_illegal_opcode);
    take(16'h0060, 32'h60, 1'b1);
    pulse(i_debug_trap);
    take(16'h0060, 32'h60, 1'b1);
    $display("test exceptions done");
  endtask
  task automatic t_nmi();
    step(1);
    i_watchdog_a_overflow = 1'b1;
    i_watchdog_b_overflow = 1'b1;
    step(1);
    i_watchdog_a_overflow = 1'b0;
    i_watchdog_b_overflow = 1'b0;
    take(16'h0030, 32'h30, 1'b1);
    idle();
    pulse(i_watchdog_a_overflow);
    take(16'h0020, 32'h20, 1'b1);
    i_nmi_pin = 1'b1;
    take(16'h0010, 32'h10, 1'b1);
    i_nmi_pin = 1'b0;
    idle();
    // Falling, both and no-edge selections of the non-maskable pin
    i_nmi_edge_sel = 2'h2;
    i_nmi_pin = 1'b1;
    idle();
    i_nmi_pin = 1'b0;
    take(16'h0010, 32'h10, 1'b1);
    i_nmi_edge_sel = 2'h3;
    i_nmi_pin = 1'b1;
    take(16'h0010, 32'h10, 1'b1);
    i_nmi_pin = 1'b0;
    take(16'h0010, 32'h10, 1'b1);
    i_nmi_edge_sel = 2'h0;
    i_nmi_pin = 1'b1;
    idle();
    i_nmi_pin = 1'b0;
    idle();
    i_nmi_edge_sel = 2'h1;
    // Slow core; a held-off maskable must not block a watchdog request
    delay = 4'h5;
    i_int_disable = 1'b1;
    i_periph_req[10] = 1'b1;
    step(1);
    i_periph_req[10] = 1'b0;
    pulse(i_watchdog_a_overflow);
    take(16'h0020, 32'h20, 1'b1);
    idle();
    i_int_disable = 1'b0;
    take(16'h0120, 32'h120, 1'b0);
    delay = 4'h0;
    $display("test nonmaskable done");
  endtask
  task automatic t_mask();
    i_watchdog_a_nmi_mode = 1'b0;
    i_watchdog_b_nmi_mode = 1'b0;
    pulse(i_watchdog_a_overflow);
    take(16'h0080, 32'h80, 1'b0);
    pulse(i_watchdog_b_overflow);
    idle();
    for (int k = 0; k < 7; k++) begin
      i_ext_pin[k] = 1'b1;
      take(16'h0090 + 16'(k * 16), 32'h90 + 32'(k * 16), 1'b0);
    end
    // Pin 0 switched to falling edge; the other pins stay high and quiet
    i_ext_edge_sel[1:0] = 2'h2;
    i_ext_pin[0] = 1'b0;
    take(16'h0090, 32'h90, 1'b0);
    // Peripheral sources 10-21 at once, held back by the mask first
    i_mask = '1;
    i_periph_req = 14'h3ffc;
    step(1);
    i_periph_req = '0;
    idle();
    i_mask = '0;
    for (int s = 10; s < 22; s++)
      take(16'h0080 + 16'(s * 16), 32'h80 + 32'(s * 16), 1'b0);
    $display("test maskable done");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    step(6);
    i_resetn = 1'b1;
    t_reset();
    t_exc();
    t_nmi();
    t_mask();
    give_verdict();
  end
  // Tests need well under a thousand cycles; this span means a hang
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule // tb
